// ===== core/pwmdt_pkg.sv
/*
 * Constants, types and register map for the PWM dead-time and ADC trigger block.
 * Assumes one system clock that serves as the dead-time counter clock
 * (four times the instruction rate) and an AHB-Lite master on the register side.
 */
package pwmdt_pkg;
   // ==========================================================
   // Sizes
   localparam int NUM_GEN = 4;                    // Generators, one output pair each
   localparam int DT_W    = 12;                   // Dead-time value and counter width
   localparam int TB_W    = 13;                   // Time base and compare width
   // ==========================================================
   // Timing: one counter step per system clock edge
   localparam int CLK_SYS_PERIOD_NS = 10;
   localparam int DT_CLKS_PER_STEP  = 1;
   // ==========================================================
   // Register map, byte addresses
   localparam logic [7:0] OFF_TBCTL    = 8'h00;   // time_base_control
   localparam logic [7:0] OFF_SEVCMP   = 8'h04;   // special_event_compare
   localparam logic [7:0] OFF_IRQST    = 8'h08;   // Sticky event status, write one to clear
   localparam logic [7:0] OFF_IRQMSK   = 8'h0C;   // Event mask, same layout
   localparam logic [7:0] OFF_GEN_BASE = 8'h10;   // First generator block
   localparam logic [7:0] OFF_GEN_END  = 8'h90;   // One past the last generator block
   localparam int         GEN_SHIFT    = 5;       // 32-byte stride per generator
   localparam logic [4:0] GOFF_CTL     = 5'h00;   // generator_control
   localparam logic [4:0] GOFF_DTV     = 5'h04;   // dead_time_value
   localparam logic [4:0] GOFF_ALT     = 5'h08;   // alternate_dead_time_value
   localparam logic [4:0] GOFF_TRIG    = 5'h0C;   // generator_trigger_compare
   localparam logic [4:0] GOFF_TRGCTL  = 5'h10;   // trigger_control
   // ==========================================================
   // Field positions
   localparam int CTL_DTC_LSB = 0;                // dead_time_control_select, 2 bits
   localparam int CTL_TIE_BIT = 2;                // trigger_interrupt_enable
   localparam int CTL_BUSY_BIT = 8;               // Read-only: dead-time count running
   localparam int IRQ_SEV_BIT = 0;                // Special event status bit
   localparam int IRQ_TRG_LSB = 1;                // Generator trigger status bits
   localparam int IRQ_W       = 5;
   // ==========================================================
   // Dead-time modes
   localparam logic [1:0] DTC_NORMAL = 2'b00;     // Same value for both edges
   localparam logic [1:0] DTC_DUAL   = 2'b01;     // Alternate value for low output
   localparam logic [1:0] DTC_OFF    = 2'b11;     // No dead time
   // ==========================================================
   // AHB-Lite codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic       HRESP_OKAY    = 1'b0;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      BUS_IDLE  = 3'b001,
      BUS_WRITE = 3'b010,
      BUS_READ  = 3'b100
   } pwmdt_bus_e;

   typedef struct packed {
      logic [1:0]      dtc;       // dead_time_control_select
      logic            tie;       // trigger_interrupt_enable
      logic [DT_W-1:0] dtv;       // dead_time_value
      logic [DT_W-1:0] alt;       // alternate_dead_time_value
      logic [TB_W-1:0] trig;      // generator_trigger_compare
      logic [2:0]      div;       // trigger_divide_ratio
      logic            cmpPrev;   // Last duty comparison level
      logic            pend;      // A delayed transition is waiting
      logic            pendHigh;  // Waiting output is the high one
      logic [DT_W-1:0] cnt;       // Dead-time down counter
      logic            trigPrev;  // Last trigger match level
      logic [2:0]      divCnt;    // Trigger divider count
      logic            high;      // High output of the pair
      logic            low;       // Low output of the pair
      logic            fine;      // Fine-adjust bit of the running count
      logic            adcTrig;   // Divided trigger pulse to the ADC
   } pwmdt_gen_s;

   typedef struct packed {
      pwmdt_bus_e        busSt;
      logic [7:0]        addr;
      logic              ready;
      logic [31:0]       rdata;
      logic [3:0]        postscale;   // special_event_postscale
      logic [TB_W-1:0]   sevCmp;
      logic              sevPrev;
      logic [3:0]        psCnt;
      logic              sevTrig;
      logic [IRQ_W-1:0]  irqSt;
      logic [IRQ_W-1:0]  irqMsk;
      logic              irq;
      pwmdt_gen_s [NUM_GEN-1:0] gen;
   } pwmdt_state_s;

   typedef struct packed {
      logic [NUM_GEN-1:0]           dutyCmp;       // Duty comparison results
      logic [TB_W-1:0]              primaryCount;  // primary_time_base_counter
      logic [NUM_GEN-1:0][TB_W-1:0] localCount;    // Local time base counters
      logic [NUM_GEN-1:0][TB_W-1:0] localPeriod;   // Local period values
   } pwmdt_timing_s;

   typedef struct packed {
      logic [NUM_GEN-1:0] high;
      logic [NUM_GEN-1:0] low;
      logic [NUM_GEN-1:0] fine;
      logic [NUM_GEN-1:0] adcTrig;
      logic               sevTrig;
   } pwmdt_drive_s;
endpackage

// ===== core/pwmdt_top.sv
/*
 * Dead-time insertion for four complementary pairs, special event trigger
 * with postscaler, per-generator ADC triggers, and an AHB-Lite register slave.
 * Assumes the time bases and duty comparators sit outside and are synchronous
 * to clk_sys, and that clk_sys is the dead-time counter clock.
 */
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module pwmdt_top (
   input  wire logic                 clk_sys,
   input  wire logic                 reset_n,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [31:0]               hrdata,
   input  wire pwmdt_pkg::pwmdt_timing_s timing,
   output pwmdt_pkg::pwmdt_drive_s   drive,
   output logic                      irq
);
   import pwmdt_pkg::*;

   // ==========================================================
   // State and helpers
   pwmdt_state_s st_r;                        // All block state
   pwmdt_state_s st_nxt;                      // Next state
   logic [NUM_GEN-1:0] riseEv;                // Duty comparison rose
   logic [NUM_GEN-1:0] fallEv;                // Duty comparison fell
   logic [NUM_GEN-1:0] trigEv;                // Local trigger match event
   logic               sevEv;                 // Primary compare match event
   logic               sevWr;                 // Write to special_event_compare
   logic               takeAddr;              // Address phase accepted

   // ==========================================================
   // Decode of the generator area: hit flag, index, offset within block
   function automatic logic [7:0] genDecode(input logic [7:0] a);
      logic [7:0] rel;
      rel = a - OFF_GEN_BASE;
      genDecode = {(a >= OFF_GEN_BASE) && (a < OFF_GEN_END), rel[6:0]};
   endfunction

   // Dead-time count loaded from a value; the lowest bit is left out
   function automatic logic [DT_W-1:0] dtLoad(input logic [DT_W-1:0] v);
      dtLoad = {1'b0, v[DT_W-1:1]};
   endfunction

   // Register read mux
   function automatic logic [31:0] regRead(input pwmdt_state_s s, input logic [7:0] a);
      logic [7:0] d;
      logic [1:0] g;
      d = genDecode(a);
      g = d[6:5];
      regRead = 32'h0000_0000;
      case (a)
         OFF_TBCTL:  regRead = {28'h0, s.postscale};
         OFF_SEVCMP: regRead = {19'h0, s.sevCmp};
         OFF_IRQST:  regRead = {27'h0, s.irqSt};
         OFF_IRQMSK: regRead = {27'h0, s.irqMsk};
         default: begin
            if (d[7]) begin
               case ({3'b000, d[4:0]})
                  {3'b000, GOFF_CTL}:    regRead = {23'h0, s.gen[g].pend, 5'h00,
                                                    s.gen[g].tie, s.gen[g].dtc};
                  {3'b000, GOFF_DTV}:    regRead = {20'h0, s.gen[g].dtv};
                  {3'b000, GOFF_ALT}:    regRead = {20'h0, s.gen[g].alt};
                  {3'b000, GOFF_TRIG}:   regRead = {19'h0, s.gen[g].trig};
                  {3'b000, GOFF_TRGCTL}: regRead = {29'h0, s.gen[g].div};
                  default:               regRead = 32'h0000_0000;
               endcase
            end
         end
      endcase
   endfunction

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic [IRQ_W-1:0] clr;
      logic [IRQ_W-1:0] set;
      logic [7:0]       d;
      logic [1:0]       g;
      logic             cmp;
      logic             match;
      logic [2:0]       ratio;
      clr      = '0;
      set      = '0;
      d        = 8'h00;
      g        = 2'b00;
      cmp      = 1'b0;
      match    = 1'b0;
      ratio    = 3'h0;
      sevWr    = 1'b0;
      riseEv   = '0;
      fallEv   = '0;
      trigEv   = '0;
      st_nxt   = st_r;
      st_nxt.sevTrig = 1'b0;
      takeAddr = hsel && hready && htrans[1];

      // Bus data phase
      case (st_r.busSt)
         BUS_WRITE: begin
            d = genDecode(st_r.addr);
            g = d[6:5];
            case (st_r.addr)
               OFF_TBCTL:  st_nxt.postscale = hwdata[3:0];
               OFF_SEVCMP: begin
                  st_nxt.sevCmp = hwdata[TB_W-1:0];
                  sevWr = 1'b1;
               end
               OFF_IRQST:  clr = hwdata[IRQ_W-1:0];
               OFF_IRQMSK: st_nxt.irqMsk = hwdata[IRQ_W-1:0];
               default: begin
                  // Unmapped addresses are ignored
                  if (d[7]) begin
                     case ({3'b000, d[4:0]})
                        {3'b000, GOFF_CTL}: begin
                           st_nxt.gen[g].dtc = hwdata[CTL_DTC_LSB+:2];
                           st_nxt.gen[g].tie = hwdata[CTL_TIE_BIT];
                        end
                        {3'b000, GOFF_DTV}:    st_nxt.gen[g].dtv = hwdata[DT_W-1:0];
                        {3'b000, GOFF_ALT}:    st_nxt.gen[g].alt = hwdata[DT_W-1:0];
                        {3'b000, GOFF_TRIG}:   st_nxt.gen[g].trig = hwdata[TB_W-1:0];
                        {3'b000, GOFF_TRGCTL}: st_nxt.gen[g].div = hwdata[2:0];
                        default:               st_nxt.gen[g].div = st_r.gen[g].div;
                     endcase
                  end
               end
            endcase
         end
         BUS_READ: begin
            // One wait state so a write just before is already visible
            st_nxt.rdata = regRead(st_r, st_r.addr);
            st_nxt.ready = 1'b1;
         end
         default: st_nxt.ready = 1'b1;
      endcase

      // Bus address phase
      st_nxt.busSt = BUS_IDLE;
      if (takeAddr) begin
         st_nxt.addr  = haddr[7:0];
         st_nxt.busSt = hwrite ? BUS_WRITE : BUS_READ;
         if (!hwrite) begin
            st_nxt.ready = 1'b0;
         end
      end

      // Special event trigger, never gated by an enable
      match = (timing.primaryCount == st_r.sevCmp);
      sevEv = match && !st_r.sevPrev;
      st_nxt.sevPrev = match;
      if (sevEv) begin
         set[IRQ_SEV_BIT] = 1'b1;
         if (st_r.psCnt >= st_r.postscale) begin
            st_nxt.sevTrig = 1'b1;
            st_nxt.psCnt   = 4'h0;
         end else begin
            st_nxt.psCnt = st_r.psCnt + 4'h1;
         end
      end
      if (sevWr) begin
         st_nxt.psCnt = 4'h0;
      end

      // Per-generator dead time and trigger
      for (int i = 0; i < NUM_GEN; i++) begin
         st_nxt.gen[i].adcTrig = 1'b0;
         cmp = timing.dutyCmp[i];
         riseEv[i] = cmp && !st_r.gen[i].cmpPrev;
         fallEv[i] = !cmp && st_r.gen[i].cmpPrev;
         st_nxt.gen[i].cmpPrev = cmp;
         if (st_r.gen[i].dtc == DTC_OFF) begin
            // Plain complementary pair
            st_nxt.gen[i].high = cmp;
            st_nxt.gen[i].low  = !cmp;
            st_nxt.gen[i].pend = 1'b0;
         end else if (riseEv[i]) begin
            // Low turns off now, high waits the primary interval
            st_nxt.gen[i].high     = 1'b0;
            st_nxt.gen[i].low      = 1'b0;
            st_nxt.gen[i].cnt      = dtLoad(st_r.gen[i].dtv);
            st_nxt.gen[i].fine     = st_r.gen[i].dtv[0];
            st_nxt.gen[i].pend     = 1'b1;
            st_nxt.gen[i].pendHigh = 1'b1;
         end else if (fallEv[i]) begin
            // High turns off now, low waits; dual mode uses the alternate value
            st_nxt.gen[i].high     = 1'b0;
            st_nxt.gen[i].low      = 1'b0;
            st_nxt.gen[i].pend     = 1'b1;
            st_nxt.gen[i].pendHigh = 1'b0;
            if (st_r.gen[i].dtc == DTC_DUAL) begin
               st_nxt.gen[i].cnt  = dtLoad(st_r.gen[i].alt);
               st_nxt.gen[i].fine = st_r.gen[i].alt[0];
            end else begin
               st_nxt.gen[i].cnt  = dtLoad(st_r.gen[i].dtv);
               st_nxt.gen[i].fine = st_r.gen[i].dtv[0];
            end
         end else if (st_r.gen[i].pend) begin
            // One step per clock; release only at zero
            if (st_r.gen[i].cnt == '0) begin
               st_nxt.gen[i].pend = 1'b0;
               if (st_r.gen[i].pendHigh) begin
                  st_nxt.gen[i].high = 1'b1;
               end else begin
                  st_nxt.gen[i].low = 1'b1;
               end
            end else begin
               st_nxt.gen[i].cnt = st_r.gen[i].cnt - 12'h001;
            end
         end

         // Trigger: compares beyond the period never match
         match = (timing.localCount[i] == st_r.gen[i].trig) &&
                 (st_r.gen[i].trig <= timing.localPeriod[i]);
         trigEv[i] = match && !st_r.gen[i].trigPrev;
         st_nxt.gen[i].trigPrev = match;
         ratio = (st_r.gen[i].div == 3'h0) ? 3'h1 : st_r.gen[i].div;
         if (trigEv[i]) begin
            set[IRQ_TRG_LSB+i] = st_r.gen[i].tie;
            if (st_r.gen[i].divCnt >= ratio - 3'h1) begin
               st_nxt.gen[i].adcTrig = 1'b1;
               st_nxt.gen[i].divCnt  = 3'h0;
            end else begin
               st_nxt.gen[i].divCnt = st_r.gen[i].divCnt + 3'h1;
            end
         end
      end

      // Sticky status: a new event wins over a clear
      st_nxt.irqSt = (st_r.irqSt & ~clr) | set;
      st_nxt.irq   = |(st_nxt.irqSt & st_nxt.irqMsk);
   end

   // ==========================================================
   // State register; reset also clears the postscaler
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_r       <= '0;
         st_r.busSt <= BUS_IDLE;
         st_r.ready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Outputs straight from state
   assign hreadyout = st_r.ready;
   assign hresp     = HRESP_OKAY;
   assign hrdata    = st_r.rdata;
   assign irq       = st_r.irq;
   always_comb begin
      drive.sevTrig = st_r.sevTrig;
      for (int i = 0; i < NUM_GEN; i++) begin
         drive.high[i]    = st_r.gen[i].high;
         drive.low[i]     = st_r.gen[i].low;
         drive.fine[i]    = st_r.gen[i].fine;
         drive.adcTrig[i] = st_r.gen[i].adcTrig;
      end
   end

   // ==========================================================
   // Checks on generator 0 and the special event path
   logic [DT_W-1:0] dtvLoad0;                 // Primary load value, generator 0
   logic [DT_W-1:0] altLoad0;                 // Alternate load value, generator 0
   logic            cmp0;                     // Duty comparison, generator 0
   assign dtvLoad0 = dtLoad(st_r.gen[0].dtv);
   assign altLoad0 = dtLoad(st_r.gen[0].alt);
   assign cmp0     = timing.dutyCmp[0];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   property p_neverBoth;
      !(st_r.gen[0].high && st_r.gen[0].low);
   endproperty
   a_neverBoth: assert property (p_neverBoth)
      else $error("both outputs of pair 0 high");
   property p_riseDrops;
      riseEv[0] && st_r.gen[0].dtc != DTC_OFF |=> !st_r.gen[0].low && !st_r.gen[0].high;
   endproperty
   a_riseDrops: assert property (p_riseDrops)
      else $error("rise did not turn low off");
   property p_riseLoad;
      riseEv[0] && st_r.gen[0].dtc != DTC_OFF |=> st_r.gen[0].cnt == $past(dtvLoad0);
   endproperty
   a_riseLoad: assert property (p_riseLoad)
      else $error("rise loaded wrong dead-time count");
   // A new edge restarts the count, so only quiet cycles are held to one step
   property p_holdCount;
      st_r.gen[0].pend && st_r.gen[0].pendHigh && st_r.gen[0].cnt != '0 &&
      st_r.gen[0].dtc != DTC_OFF && !riseEv[0] && !fallEv[0]
      |=> !st_r.gen[0].high ##0 st_r.gen[0].cnt == $past(st_r.gen[0].cnt) - 12'h001;
   endproperty
   a_holdCount: assert property (p_holdCount)
      else $error("high asserted before count expired");
   property p_zeroRelease;
      st_r.gen[0].pend && st_r.gen[0].pendHigh && st_r.gen[0].cnt == '0 &&
      st_r.gen[0].dtc != DTC_OFF && !riseEv[0] && !fallEv[0] |=> st_r.gen[0].high;
   endproperty
   a_zeroRelease: assert property (p_zeroRelease)
      else $error("high not released at zero count");
   property p_dualAlt;
      fallEv[0] && st_r.gen[0].dtc == DTC_DUAL |=> st_r.gen[0].cnt == $past(altLoad0)
         ##0 !st_r.gen[0].pendHigh;
   endproperty
   a_dualAlt: assert property (p_dualAlt)
      else $error("dual mode fall did not use alternate value");
   property p_offFollows;
      st_r.gen[0].dtc == DTC_OFF |=> st_r.gen[0].high == $past(cmp0) && st_r.gen[0].low != $past(cmp0);
   endproperty
   a_offFollows: assert property (p_offFollows)
      else $error("disabled pair does not follow comparison");
   property p_sevCause;
      st_r.sevTrig |-> $past(sevEv);
   endproperty
   a_sevCause: assert property (p_sevCause)
      else $error("special event pulse without match");
   property p_psOne;
      sevEv && st_r.postscale == 4'h0 |=> st_r.sevTrig ##1 !st_r.sevTrig;
   endproperty
   a_psOne: assert property (p_psOne)
      else $error("1:1 postscale did not pass the match");
   property p_psClear;
      sevWr |=> st_r.psCnt == 4'h0;
   endproperty
   a_psClear: assert property (p_psClear)
      else $error("compare write did not clear postscaler");
   property p_trigCause;
      st_r.gen[0].adcTrig |-> $past(trigEv[0]);
   endproperty
   a_trigCause: assert property (p_trigCause)
      else $error("trigger pulse without in-range match");
   property p_trigIrq;
      trigEv[0] && st_r.gen[0].tie |=> st_r.irqSt[IRQ_TRG_LSB];
   endproperty
   a_trigIrq: assert property (p_trigIrq)
      else $error("trigger event did not set status");
   property p_divOne;
      trigEv[0] && st_r.gen[0].div <= 3'h1 |=> st_r.gen[0].adcTrig;
   endproperty
   a_divOne: assert property (p_divOne)
      else $error("undivided trigger not passed");

   // Falling side: high drops at once, the low output waits its own count
   property p_fallDrops;
      fallEv[0] && st_r.gen[0].dtc != DTC_OFF |=> !st_r.gen[0].high && !st_r.gen[0].low
         ##0 !st_r.gen[0].pendHigh;
   endproperty
   a_fallDrops: assert property (p_fallDrops)
      else $error("fall did not turn high off");
   // Low output comes back only once its count has run out
   property p_lowRelease;
      st_r.gen[0].pend && !st_r.gen[0].pendHigh && st_r.gen[0].cnt == '0 &&
      st_r.gen[0].dtc != DTC_OFF && !riseEv[0] && !fallEv[0]
      |=> st_r.gen[0].low && !st_r.gen[0].high;
   endproperty
   a_lowRelease: assert property (p_lowRelease)
      else $error("low not released at zero count");
   // A compare beyond the local period must never reach the converter
   property p_trigRange;
      st_r.gen[0].trig > timing.localPeriod[0] |=> !st_r.gen[0].adcTrig;
   endproperty
   a_trigRange: assert property (p_trigRange)
      else $error("trigger pulse from out-of-range compare");

   c_deadTime: cover property (riseEv[0] && st_r.gen[0].cnt == '0 ##[2:40] st_r.gen[0].high);
   c_sevTrig:  cover property (sevEv ##1 st_r.sevTrig);
   c_adcTrig:  cover property (st_r.gen[0].adcTrig && st_r.gen[0].div > 3'h1);
   c_irq:      cover property (st_r.irq);
   c_dualFall: cover property (fallEv[0] && st_r.gen[0].dtc == DTC_DUAL ##1 st_r.gen[0].pend);
endmodule

// ===== sim/pwmdt_far_model.sv
/* Far-side model: gate drivers and ADC input of the pair outputs.
   Assumes drive is synchronous to clk_sys. */
`timescale 1ns/1ps
module pwmdt_far_model (
   input wire logic                    clk_sys,
   input wire logic                    reset_n,
   input wire pwmdt_pkg::pwmdt_drive_s drive,
   output logic [3:0][15:0]            cnt
);
   import pwmdt_pkg::*;
   // ==========================================================
   // Pulse counters: 0 special event, 1-2 ADC triggers of gen 0-1
   // Slot 3 counts shoot-through, fatal for a real bridge
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= '0;
      end else begin
         cnt[0] <= cnt[0] + 16'(drive.sevTrig);
         cnt[1] <= cnt[1] + 16'(drive.adcTrig[0]);
         cnt[2] <= cnt[2] + 16'(drive.adcTrig[1]);
         cnt[3] <= cnt[3] + 16'(|(drive.high & drive.low));
      end
   end
endmodule

// ===== sim/pwm_dead_time_and_adc_trigger_tb.sv
/* Self-checking bench: registers, dead time, special event and triggers.
   Assumes one AHB-Lite slave whose hreadyout is the bus hready. */
`timescale 1ns/1ps
module pwm_dead_time_and_adc_trigger_tb;
   import pwmdt_pkg::*;
   logic clk_sys = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdN, rd;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, irq, rdyN, run = 1'b0;
   logic [3:0] duty = 4'h0;
   logic [12:0] pc = 13'h0;
   logic [3:0][15:0] cnt, cnt0;
   pwmdt_timing_s timing;
   pwmdt_drive_s drive;
   int fails = 0, num_checks = 0, k;
   // Ordinary rows: address, write data, readback
   localparam logic [71:0] ROWS [9] = '{{8'h00, 32'hFFFFFFFF, 32'hF},
      {8'h04, 32'hFFFFFFFF, 32'h1FFF}, {8'h10, 32'hFFFFFFFF, 32'h7},
      {8'h14, 32'hFFFFFFFF, 32'hFFF}, {8'h18, 32'hFFFFFFFF, 32'hFFF},
      {8'h1C, 32'hFFFFFFFF, 32'h1FFF}, {8'h20, 32'hFFFFFFFF, 32'h7},
      {8'h0C, 32'hFFFFFFFF, 32'h1F}, {8'hF0, 32'hFFFFFFFF, 32'h0}};
   // All bases share one 20-count counter; pair 1 has a shorter period
   assign timing = '{duty, pc, {4{pc}}, {13'h13, 13'h13, 13'h08, 13'h13}};
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (run) pc <= (pc == 13'h13) ? 13'h0 : pc + 13'h1;
   // Sampled mid-cycle so the master never races the slave
   always @(negedge clk_sys) {rdyN, rdN} = {hreadyout, hrdata};
   pwmdt_top i_pwmdt_top (.clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .timing, .drive, .irq);
   pwmdt_far_model i_pwmdt_far_model (.clk_sys, .reset_n, .drive, .cnt);
   // ==========================================================
   task automatic conclude;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic waitRdy;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk_sys);
         if (rdyN === 1'b1) return;
      end
      fails++;
      conclude();
   endtask
   // One single AHB-Lite word transfer, read data left in rd
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      waitRdy();
      htrans <= 2'b00;
      hwdata <= d;
      waitRdy();
      rd = rdN;
   endtask
   // Duty edge on pair 0, edges until the waiting output rises
   task automatic edgeLat(input logic lvl);
      duty[0] <= lvl;
      for (k = 1; k < 5000; k++) begin
         @(posedge clk_sys);
         #1;
         if ((lvl ? drive.high[0] : drive.low[0]) === 1'b1) break;
      end
      if (k == 5000) begin
         fails++;
         conclude();
      end
      repeat (40) @(posedge clk_sys);
   endtask
   // ==========================================================
   initial begin
      repeat (10) @(posedge clk_sys);
      // Still in reset: outputs idle, bus ready with an OKAY response
      chk(32'({drive, irq, hreadyout, hresp}), 32'h2);
      chk(hrdata, 32'h0);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      xfer(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      foreach (ROWS[i]) begin
         xfer(1'b1, ROWS[i][71:64], ROWS[i][63:32]);
         xfer(1'b0, ROWS[i][71:64], 32'h0);
         chk(rd, ROWS[i][31:0]);
      end
      xfer(1'b1, 8'h0C, 32'h0);
      xfer(1'b1, 8'h10, 32'h0);
      xfer(1'b1, 8'h14, 32'hB);
      xfer(1'b1, 8'h18, 32'h14);
      // Waiting output rises value/2 + 2 edges after the duty change
      edgeLat(1'b1);
      chk(k, 7);
      chk(drive.fine[0], 32'h1);
      edgeLat(1'b0);
      chk(k, 7);
      xfer(1'b1, 8'h10, 32'h1);
      edgeLat(1'b1);
      chk(k, 7);
      edgeLat(1'b0);
      chk(k, 12);
      chk(drive.fine[0], 32'h0);
      xfer(1'b1, 8'h10, 32'h3);
      edgeLat(1'b1);
      chk(k, 1);
      chk(cnt[3], 32'h0);
      xfer(1'b1, 8'h10, 32'h4);
      xfer(1'b1, 8'h30, 32'h4);
      xfer(1'b1, 8'h1C, 32'h7);
      xfer(1'b1, 8'h20, 32'h3);
      xfer(1'b1, 8'h3C, 32'hC);
      xfer(1'b1, 8'h00, 32'h2);
      xfer(1'b1, 8'h04, 32'h5);
      cnt0 = cnt;
      run <= 1'b1;
      repeat (240) @(posedge clk_sys);
      run <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk(cnt[0] - cnt0[0], 32'h4);
      chk(cnt[1] - cnt0[1], 32'h4);
      chk(cnt[2] - cnt0[2], 32'h0);
      xfer(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h3);
      chk(irq, 32'h0);
      xfer(1'b1, 8'h0C, 32'h2);
      repeat (2) @(posedge clk_sys);
      chk(irq, 32'h1);
      xfer(1'b1, 8'h08, 32'h2);
      repeat (2) @(posedge clk_sys);
      chk(irq, 32'h0);
      xfer(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h1);
      conclude();
   end
endmodule
